// [rtl/ssr_pkg.sv]
package ssr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned WORD_W = 16;

  localparam logic [8:0] ADDR_MULT_TIMER  = 9'h0d0;
  localparam logic [8:0] ADDR_RESET_DUR   = 9'h0d1;
  localparam logic [8:0] ADDR_INTEG_TIME  = 9'h0d2;
  localparam logic [8:0] ADDR_SECOND_TIME = 9'h0d3;
  localparam logic [8:0] ADDR_THIRD_TIME  = 9'h0d4;
  localparam logic [8:0] ADDR_ANALOG_AMP  = 9'h0d5;
  localparam logic [8:0] ADDR_DIGITAL_AMP = 9'h0d6;

  // writable words: six reserved, snapshot_reset_timing, one reserved
  localparam int unsigned NUM_RW     = 8;
  localparam int unsigned SNAP_IDX   = 6;
  localparam logic [8:0] RW_ADDR [NUM_RW] = '{9'h0d8, 9'h0d9, 9'h0da, 9'h0db,
                                             9'h0dc, 9'h0dd, 9'h0e0, 9'h0e1};
  localparam logic [15:0] RW_RESET [NUM_RW] = '{16'h7f00, 16'h261e, 16'h160b,
                                               16'h3e2e, 16'h6368, 16'h0008,
                                               16'h3e01, 16'h5ef1};
  localparam logic [15:0] RW_MASK [NUM_RW] = '{16'h7fff, 16'h7fff, 16'h7fff,
                                              16'h7fff, 16'h7fff, 16'h007f,
                                              16'h3fff, 16'hffff};

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int unsigned AMP1_LSB    = 0;
  localparam int unsigned AMP1_W      = 5;
  localparam int unsigned AMP2_LSB    = 5;
  localparam int unsigned AMP2_W      = 8;
  localparam int unsigned DAMP_W      = 12;
  localparam int unsigned DUAL_BIT    = 12;
  localparam int unsigned TRIPLE_BIT  = 13;
  localparam int unsigned DUMMY_LSB   = 0;
  localparam int unsigned LINE_LSB    = 4;
  localparam int unsigned SNAP_FLD_W  = 4;

  typedef struct packed {
    logic [15:0] mult_timer;
    logic [15:0] reset_duration;
    logic [15:0] integration_time;
    logic [15:0] second_slope_time;
    logic [15:0] third_slope_time;
    logic [4:0]  first_amp_setting;
    logic [7:0]  second_amp_setting;
    logic [11:0] digital_amp_setting;
    logic        dual_slope;
    logic        triple_slope;
  } ssr_status_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } ssr_req_t;

endpackage

// [rtl/ssr_frame_capture.sv]
module ssr_frame_capture
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 frame_start_i,
  input  wire logic                 snapshot_mode_i,
  input  wire logic                 master_mode_i,
  input  wire ssr_pkg::ssr_status_t live_i,
  output ssr_pkg::ssr_status_t      held_o
);

  ssr_pkg::ssr_status_t held_q;

  // ****************************************************************
  // once-per-frame capture
  // ****************************************************************
  // sampled only at frame start so a read never mixes two frames
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      held_q <= '0;
    else if (frame_start_i)
    begin
      held_q <= live_i;
      if (!(master_mode_i && snapshot_mode_i))
        held_q.mult_timer <= '0;
      if (!master_mode_i)
      begin
        held_q.reset_duration    <= '0;
        held_q.integration_time  <= '0;
        held_q.second_slope_time <= '0;
        held_q.third_slope_time  <= '0;
      end
    end
  end

  assign held_o = held_q;

endmodule

// [rtl/ssr_bank.sv]
// How it works
// - timer word valid only master snapshot
// - reset length word, zero in slave
// - three exposure words, zero in slave
// - analog gains and digital gain packed
// - dummy line count field, default one
// - reset release line field, default zero
// - rolling shutter ignores both snapshot fields
module ssr_bank #(
  parameter int unsigned WORD_W = 16
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire ssr_pkg::ssr_req_t    req_i,
  input  wire logic                 frame_start_i,
  input  wire logic                 snapshot_mode_i,
  input  wire logic                 master_mode_i,
  input  wire ssr_pkg::ssr_status_t live_i,
  output logic [15:0]               rdata_o,
  output logic                      rvalid_o,
  output logic [3:0]                dummy_lines_o,
  output logic [3:0]                reset_release_line_o
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (WORD_W != ssr_pkg::WORD_W)
    $error("ssr_bank serves only 16-bit words");

  ssr_pkg::ssr_status_t held;
  logic [15:0]          rw_q [ssr_pkg::NUM_RW];
  logic [15:0]          rdata_q;
  logic [15:0]          rdata_d;
  logic                 rvalid_q;
  logic [3:0]           dummy_q;
  logic [3:0]           line_q;
  logic [3:0]           cfg_dummy;
  logic [3:0]           cfg_line;

  ssr_frame_capture u_capture
  (
    .core_clk_i      (core_clk_i),
    .rst_i           (rst_i),
    .frame_start_i   (frame_start_i),
    .snapshot_mode_i (snapshot_mode_i),
    .master_mode_i   (master_mode_i),
    .live_i          (live_i),
    .held_o          (held)
  );

  // ****************************************************************
  // writable words
  // ****************************************************************
  // status addresses are absent from this table, so writes there fall away
  for (genvar i = 0; i < ssr_pkg::NUM_RW; i++)
  begin : g_rw
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
        rw_q[i] <= ssr_pkg::RW_RESET[i];
      else if (req_i.wr && req_i.addr == ssr_pkg::RW_ADDR[i])
        rw_q[i] <= req_i.wdata & ssr_pkg::RW_MASK[i];
    end
  end

  assign cfg_dummy = rw_q[ssr_pkg::SNAP_IDX][ssr_pkg::DUMMY_LSB +: ssr_pkg::SNAP_FLD_W];
  assign cfg_line  = rw_q[ssr_pkg::SNAP_IDX][ssr_pkg::LINE_LSB +: ssr_pkg::SNAP_FLD_W];

  // ****************************************************************
  // snapshot timing outputs
  // ****************************************************************
  // zero in rolling shutter so the sequencer never sees stale settings
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dummy_q <= '0;
      line_q  <= '0;
    end
    else if (snapshot_mode_i)
    begin
      dummy_q <= cfg_dummy;
      line_q  <= cfg_line;
    end
    else
    begin
      dummy_q <= '0;
      line_q  <= '0;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb
  begin
    rdata_d = '0;
    unique case (req_i.addr)
      ssr_pkg::ADDR_MULT_TIMER:  rdata_d = held.mult_timer;
      ssr_pkg::ADDR_RESET_DUR:   rdata_d = held.reset_duration;
      ssr_pkg::ADDR_INTEG_TIME:  rdata_d = held.integration_time;
      ssr_pkg::ADDR_SECOND_TIME: rdata_d = held.second_slope_time;
      ssr_pkg::ADDR_THIRD_TIME:  rdata_d = held.third_slope_time;
      ssr_pkg::ADDR_ANALOG_AMP:
      begin
        rdata_d[ssr_pkg::AMP1_LSB +: ssr_pkg::AMP1_W] = held.first_amp_setting;
        rdata_d[ssr_pkg::AMP2_LSB +: ssr_pkg::AMP2_W] = held.second_amp_setting;
      end
      ssr_pkg::ADDR_DIGITAL_AMP:
      begin
        rdata_d[ssr_pkg::DAMP_W-1:0]      = held.digital_amp_setting;
        rdata_d[ssr_pkg::DUAL_BIT]        = held.dual_slope;
        rdata_d[ssr_pkg::TRIPLE_BIT]      = held.triple_slope;
      end
      default:
      begin
        for (int k = 0; k < ssr_pkg::NUM_RW; k++)
          if (req_i.addr == ssr_pkg::RW_ADDR[k])
            rdata_d = rw_q[k];
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= req_i.rd;
  end

  // data holds between reads
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= '0;
    else if (req_i.rd)
      rdata_q <= rdata_d;
  end

  assign rdata_o              = rdata_q;
  assign rvalid_o             = rvalid_q;
  assign dummy_lines_o        = dummy_q;
  assign reset_release_line_o = line_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_timer_gated;
    @(posedge core_clk_i) disable iff (rst_i)
    frame_start_i && !(master_mode_i && snapshot_mode_i) |=> held.mult_timer == 16'h0000;
  endproperty
  a_timer_gated: assert property (p_timer_gated)
    else $error("timer word not cleared outside master snapshot");

  property p_timer_read;
    @(posedge core_clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ssr_pkg::ADDR_MULT_TIMER |=>
      rvalid_o && rdata_o == $past(held.mult_timer);
  endproperty
  a_timer_read: assert property (p_timer_read)
    else $error("timer read returned wrong word");

  property p_reset_slave;
    @(posedge core_clk_i) disable iff (rst_i)
    frame_start_i && !master_mode_i |=> held.reset_duration == 16'h0000;
  endproperty
  a_reset_slave: assert property (p_reset_slave)
    else $error("reset length reported in slave mode");

  property p_exposure_slave;
    @(posedge core_clk_i) disable iff (rst_i)
    frame_start_i && !master_mode_i |=> (held.integration_time | held.second_slope_time
                                         | held.third_slope_time) == 16'h0000;
  endproperty
  a_exposure_slave: assert property (p_exposure_slave)
    else $error("exposure reported in slave mode");

  property p_gain_pack;
    @(posedge core_clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ssr_pkg::ADDR_ANALOG_AMP |=>
      rdata_o == {3'h0, $past(held.second_amp_setting), $past(held.first_amp_setting)};
  endproperty
  a_gain_pack: assert property (p_gain_pack)
    else $error("analog gain word packed wrongly");

  property p_dummy_follow;
    @(posedge core_clk_i) disable iff (rst_i)
    snapshot_mode_i |=> dummy_lines_o == $past(cfg_dummy);
  endproperty
  a_dummy_follow: assert property (p_dummy_follow)
    else $error("dummy line count not applied");

  property p_line_follow;
    @(posedge core_clk_i) disable iff (rst_i)
    snapshot_mode_i |=> reset_release_line_o == $past(cfg_line);
  endproperty
  a_line_follow: assert property (p_line_follow)
    else $error("reset release line not applied");

  property p_rolling_ignore;
    @(posedge core_clk_i) disable iff (rst_i)
    !snapshot_mode_i |=> dummy_lines_o == 4'h0 && reset_release_line_o == 4'h0;
  endproperty
  a_rolling_ignore: assert property (p_rolling_ignore)
    else $error("snapshot fields leaked into rolling shutter");

  property p_hold_between_frames;
    @(posedge core_clk_i) disable iff (rst_i)
    !frame_start_i |=> $stable(held);
  endproperty
  a_hold_between_frames: assert property (p_hold_between_frames)
    else $error("status changed without frame start");

  property p_ro_write_ignored;
    @(posedge core_clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == ssr_pkg::ADDR_DIGITAL_AMP |=>
      rw_q[ssr_pkg::SNAP_IDX] == $past(rw_q[ssr_pkg::SNAP_IDX]);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("write to read-only word changed storage");

  c_master_snap_frame: cover property (@(posedge core_clk_i) disable iff (rst_i)
    frame_start_i && master_mode_i && snapshot_mode_i);
  c_cfg_write: cover property (@(posedge core_clk_i) disable iff (rst_i)
    req_i.wr && req_i.addr == ssr_pkg::RW_ADDR[ssr_pkg::SNAP_IDX]);
  c_gain_read: cover property (@(posedge core_clk_i) disable iff (rst_i)
    req_i.rd && req_i.addr == ssr_pkg::ADDR_ANALOG_AMP);

endmodule

// [dv/ssr_host.sv]
module ssr_host
(
  input  wire logic         core_clk_i,
  output ssr_pkg::ssr_req_t req_o,
  input  wire logic [15:0]  rdata_i,
  input  wire logic         rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // serial front end stand-in, one word per transfer
  // ****************************************************************
  initial req_o = '0;

  task automatic xfer(input logic wr, input logic [8:0] addr, input logic [15:0] wdata,
                      output logic [15:0] data, output logic valid);
    @(posedge core_clk_i);
    #1;
    req_o = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
    @(posedge core_clk_i);
    #1;
    data = rdata_i;
    valid = rvalid_i;
    // released lines flip so a stale address never looks valid
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

// [dv/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 core_clk_i = 1'b0;
  logic                 rst_i      = 1'b1;
  logic                 frame_start;
  logic                 snap;
  logic                 master;
  ssr_pkg::ssr_status_t live;
  ssr_pkg::ssr_req_t    req;
  logic [15:0]          rdata;
  logic                 rvalid;
  logic [3:0]           dummy;
  logic [3:0]           rel;
  int                   fails = 0;
  int                   samples_checked = 0;
  logic [15:0]          m [logic [8:0]];
  logic [8:0]           addrs [17] = '{9'h0d0, 9'h0d1, 9'h0d2, 9'h0d3, 9'h0d4, 9'h0d5,
                                       9'h0d6, 9'h0d7, 9'h0d8, 9'h0d9, 9'h0da, 9'h0db,
                                       9'h0dc, 9'h0dd, 9'h0de, 9'h0e0, 9'h0e1};

  always #10 core_clk_i = ~core_clk_i;

  ssr_bank ssr_bank_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req),
    .frame_start_i(frame_start), .snapshot_mode_i(snap), .master_mode_i(master),
    .live_i(live), .rdata_o(rdata), .rvalid_o(rvalid), .dummy_lines_o(dummy),
    .reset_release_line_o(rel));

  ssr_host ssr_host_inst (.core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata),
    .rvalid_i(rvalid));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic reset_model();
    m.delete();
    for (int i = 0; i < ssr_pkg::NUM_RW; i++)
      m[ssr_pkg::RW_ADDR[i]] = ssr_pkg::RW_RESET[i];
  endtask

  task automatic rd_chk(input logic [8:0] a);
    logic [15:0] d;
    logic        v;
    ssr_host_inst.xfer(1'b0, a, 16'h0000, d, v);
    chk($sformatf("word %h", a), m.exists(a) ? m[a] : 16'h0000, d);
    chk("read valid", 16'h0001, {15'h0000, v});
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] wd);
    logic [15:0] d;
    logic        v;
    ssr_host_inst.xfer(1'b1, a, wd, d, v);
    chk("write valid", 16'h0000, {15'h0000, v});
    for (int i = 0; i < ssr_pkg::NUM_RW; i++)
      if (ssr_pkg::RW_ADDR[i] == a)
        m[a] = wd & ssr_pkg::RW_MASK[i];
  endtask

  task automatic new_live();
    logic [127:0] r;
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    live = r[$bits(live)-1:0];
  endtask

  // status words are taken once, at the frame pulse, then must stand
  task automatic frame(input logic mst, input logic snp);
    @(posedge core_clk_i);
    #1;
    master = mst;
    snap = snp;
    new_live();
    frame_start = 1'b1;
    m[9'h0d0] = (mst && snp) ? live.mult_timer : 16'h0000;
    m[9'h0d1] = mst ? live.reset_duration : 16'h0000;
    m[9'h0d2] = mst ? live.integration_time : 16'h0000;
    m[9'h0d3] = mst ? live.second_slope_time : 16'h0000;
    m[9'h0d4] = mst ? live.third_slope_time : 16'h0000;
    m[9'h0d5] = {3'h0, live.second_amp_setting, live.first_amp_setting};
    m[9'h0d6] = {2'h0, live.triple_slope, live.dual_slope, live.digital_amp_setting};
    @(posedge core_clk_i);
    #1;
    frame_start = 1'b0;
    new_live();
  endtask

  task automatic snap_chk();
    logic [15:0] w;
    repeat (2) @(posedge core_clk_i);
    #1;
    w = snap ? m[9'h0e0] : 16'h0000;
    chk("dummy lines", {12'h000, w[3:0]}, {12'h000, dummy});
    chk("release line", {12'h000, w[7:4]}, {12'h000, rel});
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(78));
    frame_start = 1'b0;
    snap = 1'b1;
    master = 1'b1;
    live = '0;
    repeat (5) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    reset_model();
    snap_chk();
    foreach (addrs[i]) rd_chk(addrs[i]);
    for (int k = 0; k < 8; k++)
    begin
      frame(k[0], k[1]);
      foreach (addrs[i]) rd_chk(addrs[i]);
    end
    foreach (addrs[i]) wr(addrs[i], 16'($urandom()));
    foreach (addrs[i]) rd_chk(addrs[i]);
    for (int s = 0; s < 4; s++)
    begin
      wr(9'h0e0, 16'($urandom()));
      @(posedge core_clk_i);
      #1;
      snap = s[0];
      snap_chk();
    end
    // asynchronous reset in mid-run brings every word back to default
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    snap = 1'b1;
    reset_model();
    snap_chk();
    foreach (addrs[i]) rd_chk(addrs[i]);
    conclude();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge core_clk_i);
    fails++;
    conclude();
  end
endmodule
